// >>> hw/gpp_pkg.sv
package gpp_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_P0_LATCH  = 6'h00;
   localparam logic [5:0] IDX_P1_LATCH  = 6'h01;
   localparam logic [5:0] IDX_P2_LATCH  = 6'h02;
   localparam logic [5:0] IDX_P3_LATCH  = 6'h03;
   localparam logic [5:0] IDX_MODE      = 6'h04;
   localparam logic [5:0] IDX_P1_DIR    = 6'h09;
   localparam logic [5:0] IDX_P3_DIR    = 6'h0a;
   localparam logic [5:0] IDX_P0_DRIVE  = 6'h0b;
   localparam logic [5:0] IDX_P0_PIN    = 6'h0c;
   localparam logic [5:0] IDX_P2_PIN    = 6'h0d;
   localparam logic [5:0] IDX_CONV      = 6'h0e;
   localparam logic [5:0] IDX_EXT_INT   = 6'h37;

   // reset values
   localparam logic [7:0] P0_LATCH_RST  = 8'hff;
   localparam logic [7:0] P0_DRIVE_RST  = 8'h00;
   localparam logic [6:0] P1_LATCH_RST  = 7'h00;
   localparam logic [6:0] P1_DIR_RST    = 7'h00;
   localparam logic [2:0] P2_LATCH_RST  = 3'h7;
   localparam logic [7:0] P3_LATCH_RST  = 8'h00;
   localparam logic [7:0] P3_DIR_RST    = 8'h00;
   localparam logic [7:0] CONV_RST      = 8'h10;
   localparam logic [7:0] EXT_INT_RST   = 8'h00;
   localparam logic [7:0] MODE_RST      = 8'h00;

   // field positions
   localparam int CONV_SEL_LSB   = 0;
   localparam int CONV_SEL_W     = 3;
   localparam int CONV_ANALOG_OFF_BIT = 4;
   localparam int EXT_INT_EN_BIT = 6;
   localparam int MODE_STOP_BIT  = 0;
   localparam int MODE_DUAL_BIT  = 1;
   localparam int AIN_BASE       = 2;
   localparam int AIN_COUNT      = 6;

   typedef struct packed {
      logic [7:0] p0;
      logic [6:0] p1;
      logic [2:0] p2;
      logic [7:0] p3;
   } gpp_pins_t;

   typedef enum logic [2:0] {
      st_idle             = 3'b001,
      st_first_bus_state  = 3'b010,
      st_second_bus_state = 3'b100
   } gpp_state_t;

endpackage

// >>> hw/gpp_sync.sv
`timescale 1ns/100ps
module gpp_sync #(
   parameter int W = 26
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         resetn_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta;

   // two stages; first stage read only by the second
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         meta  <= '0;
         q_out <= '0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // gpp_sync

// >>> hw/gpp_top.sv
// Notes on behaviour
// - outputs latched; inputs read live pin level
// - pins sampled in first bus state
// - written pin values change in second state
// - reset: port0 latch ones, drive select zero
// - drive bit: 0 open-drain, 1 push-pull
// - port0 drives latch; inputs need latch one
// - port0 latch and pin read separate
// - port1 reset: direction and latch zero
// - port1 bit1 always feeds interrupt logic
// - port1 bit0 port or interrupt input
// - interrupt pin enable at control bit six
// - port2 latch resets to all ones
// - port2 bits1-2 resonator in dual clock
// - port2 bit0 floats in stop; falling edge
// - port2 reads upper bits undefined
// - port3 reset: inputs, analog disable set
// - analog-selected port3 pins override direction
// - port3 direction one drives latch bit
// - analog and output pins read latch, input pins read pin level
// - writes never drive analog-selected pins
// - input-mode bits read pin level
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
module gpp_top (
   // clock and reset
   input  wire logic                mclk_in,
   input  wire logic                resetn_in,
   // avalon-mm slave
   input  wire logic [7:0]          address_in,
   input  wire logic                read_in,
   input  wire logic                write_in,
   input  wire logic [31:0]         writedata_in,
   input  wire logic [3:0]          byteenable_in,
   output logic      [31:0]         readdata_out,
   output logic                     waitrequest_out,
   // port pins
   input  wire gpp_pkg::gpp_pins_t  pins_in,
   output gpp_pkg::gpp_pins_t       pins_out,
   output gpp_pkg::gpp_pins_t       pins_oe_out,
   // external interrupt feeds
   output logic                     ext_int0_level_out,
   output logic                     ext_int1_level_out,
   output logic                     ext_int5_fall_out,
   // analog pin selection for the converter
   output logic      [7:0]          analog_pins_out
);
   gpp_pkg::gpp_state_t state;
   gpp_pkg::gpp_pins_t  sp;
   gpp_pkg::gpp_pins_t  next_out;
   gpp_pkg::gpp_pins_t  next_oe;
   logic [7:0]          p0_latch;
   logic [7:0]          p0_drive;
   logic [6:0]          p1_latch;
   logic [6:0]          p1_dir;
   logic [2:0]          p2_latch;
   logic [7:0]          p3_latch;
   logic [7:0]          p3_dir;
   logic [7:0]          conv_ctrl;
   logic [7:0]          ext_int_ctrl;
   logic [7:0]          mode_ctrl;
   logic [7:0]          next_p0_latch;
   logic [7:0]          next_p0_drive;
   logic [6:0]          next_p1_latch;
   logic [6:0]          next_p1_dir;
   logic [2:0]          next_p2_latch;
   logic [7:0]          next_p3_latch;
   logic [7:0]          next_p3_dir;
   logic [7:0]          next_conv;
   logic [7:0]          next_ext_int;
   logic [7:0]          next_mode;
   logic [7:0]          next_amask;
   logic [7:0]          amask;
   logic [7:0]          rd_byte;
   logic [5:0]          idx;
   logic                wr_now;
   logic                p2_bit0_prev;

   // analog pins chosen by the channel select, none when disabled
   function automatic logic [7:0] ana_mask(input logic [7:0] conv);
      logic [2:0] sel;
      logic [7:0] m;
      sel = conv[gpp_pkg::CONV_SEL_LSB +: gpp_pkg::CONV_SEL_W];
      m   = 8'h00;
      if (!conv[gpp_pkg::CONV_ANALOG_OFF_BIT] && (int'(sel) < gpp_pkg::AIN_COUNT)) begin
         m[int'(sel) + gpp_pkg::AIN_BASE] = 1'b1;
      end
      return m;
   endfunction

   // latch where selected, live pin level elsewhere
   function automatic logic [7:0] mix(input logic [7:0] lat,
                                      input logic [7:0] pin,
                                      input logic [7:0] sel);
      return (lat & sel) | (pin & ~sel);
   endfunction

   gpp_sync #(
      .W ($bits(gpp_pkg::gpp_pins_t))
   ) u_sync (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .d_in      (pins_in),
      .q_out     (sp)
   );

   assign idx    = address_in[7:2];
   assign wr_now = (state == gpp_pkg::st_second_bus_state) && write_in && byteenable_in[0];
   assign amask  = ana_mask(conv_ctrl);

   // bus cycle: idle, first state, second state
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state           <= gpp_pkg::st_idle;
         waitrequest_out <= 1'b1;
      end else begin
         case (state)
            gpp_pkg::st_idle: begin
               if (read_in || write_in) begin
                  state <= gpp_pkg::st_first_bus_state;
               end
            end
            gpp_pkg::st_first_bus_state: begin
               state           <= gpp_pkg::st_second_bus_state;
               waitrequest_out <= 1'b0;
            end
            gpp_pkg::st_second_bus_state: begin
               state           <= gpp_pkg::st_idle;
               waitrequest_out <= 1'b1;
            end
            default: begin
               state           <= gpp_pkg::st_idle;
               waitrequest_out <= 1'b1;
            end
         endcase
      end
   end

   // read data, pins taken in the first state
   always_comb begin
      case (idx)
         gpp_pkg::IDX_P0_LATCH: rd_byte = p0_latch;
         gpp_pkg::IDX_P0_PIN:   rd_byte = sp.p0;
         gpp_pkg::IDX_P0_DRIVE: rd_byte = p0_drive;
         gpp_pkg::IDX_P1_LATCH: rd_byte = mix({1'b0, p1_latch}, {1'b0, sp.p1},
                                              {1'b0, p1_dir});
         gpp_pkg::IDX_P1_DIR:   rd_byte = {1'b0, p1_dir};
         gpp_pkg::IDX_P2_LATCH: rd_byte = {5'h00, p2_latch};
         gpp_pkg::IDX_P2_PIN:   rd_byte = {5'h00, sp.p2};
         gpp_pkg::IDX_P3_LATCH: rd_byte = mix(p3_latch, sp.p3, p3_dir | amask);
         gpp_pkg::IDX_P3_DIR:   rd_byte = p3_dir;
         gpp_pkg::IDX_CONV:     rd_byte = conv_ctrl;
         gpp_pkg::IDX_EXT_INT:  rd_byte = ext_int_ctrl;
         gpp_pkg::IDX_MODE:     rd_byte = mode_ctrl;
         default:               rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         readdata_out <= 32'h0000_0000;
      end else if (state == gpp_pkg::st_first_bus_state) begin
         readdata_out <= {24'h00_0000, rd_byte};
      end
   end

   // register writes, taken in the second state
   always_comb begin
      next_p0_latch = p0_latch;
      next_p0_drive = p0_drive;
      next_p1_latch = p1_latch;
      next_p1_dir   = p1_dir;
      next_p2_latch = p2_latch;
      next_p3_latch = p3_latch;
      next_p3_dir   = p3_dir;
      next_conv     = conv_ctrl;
      next_ext_int  = ext_int_ctrl;
      next_mode     = mode_ctrl;
      if (wr_now) begin
         case (idx)
            gpp_pkg::IDX_P0_LATCH: next_p0_latch = writedata_in[7:0];
            gpp_pkg::IDX_P0_DRIVE: next_p0_drive = writedata_in[7:0];
            gpp_pkg::IDX_P1_LATCH: next_p1_latch = writedata_in[6:0];
            gpp_pkg::IDX_P1_DIR:   next_p1_dir   = writedata_in[6:0];
            gpp_pkg::IDX_P2_LATCH: next_p2_latch = writedata_in[2:0];
            gpp_pkg::IDX_P3_LATCH: next_p3_latch = writedata_in[7:0];
            gpp_pkg::IDX_P3_DIR:   next_p3_dir   = writedata_in[7:0];
            gpp_pkg::IDX_CONV:     next_conv     = writedata_in[7:0];
            gpp_pkg::IDX_EXT_INT:  next_ext_int  = writedata_in[7:0]
                                                   & (8'h01 << gpp_pkg::EXT_INT_EN_BIT);
            gpp_pkg::IDX_MODE:     next_mode     = writedata_in[7:0] & 8'h03;
            default:               next_mode     = mode_ctrl;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         p0_latch <= gpp_pkg::P0_LATCH_RST;
         p0_drive <= gpp_pkg::P0_DRIVE_RST;
      end else begin
         p0_latch <= next_p0_latch;
         p0_drive <= next_p0_drive;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         p1_latch <= gpp_pkg::P1_LATCH_RST;
         p1_dir   <= gpp_pkg::P1_DIR_RST;
         p2_latch <= gpp_pkg::P2_LATCH_RST;
      end else begin
         p1_latch <= next_p1_latch;
         p1_dir   <= next_p1_dir;
         p2_latch <= next_p2_latch;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         p3_latch <= gpp_pkg::P3_LATCH_RST;
         p3_dir   <= gpp_pkg::P3_DIR_RST;
         conv_ctrl <= gpp_pkg::CONV_RST;
      end else begin
         p3_latch  <= next_p3_latch;
         p3_dir    <= next_p3_dir;
         conv_ctrl <= next_conv;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ext_int_ctrl <= gpp_pkg::EXT_INT_RST;
         mode_ctrl    <= gpp_pkg::MODE_RST;
      end else begin
         ext_int_ctrl <= next_ext_int;
         mode_ctrl    <= next_mode;
      end
   end

   // pin drive from the values about to be latched
   always_comb begin
      next_amask     = ana_mask(next_conv);
      next_out.p0    = next_p0_latch;
      next_oe.p0     = ~next_p0_latch | next_p0_drive;
      next_out.p1    = next_p1_latch;
      next_oe.p1     = next_p1_dir;
      next_out.p2    = next_p2_latch;
      next_oe.p2     = ~next_p2_latch;
      if (next_mode[gpp_pkg::MODE_DUAL_BIT]) begin
         next_oe.p2[2:1] = 2'b00;
      end
      if (next_mode[gpp_pkg::MODE_STOP_BIT]) begin
         next_oe.p2[0] = 1'b0;
      end
      next_out.p3    = next_p3_latch & ~next_amask;
      next_oe.p3     = next_p3_dir & ~next_amask;
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pins_out        <= '{p0: gpp_pkg::P0_LATCH_RST, p1: gpp_pkg::P1_LATCH_RST,
                              p2: gpp_pkg::P2_LATCH_RST, p3: gpp_pkg::P3_LATCH_RST};
         pins_oe_out     <= '{p0: 8'h00, p1: 7'h00, p2: 3'h0, p3: 8'h00};
         analog_pins_out <= 8'h00;
      end else begin
         pins_out        <= next_out;
         pins_oe_out     <= next_oe;
         analog_pins_out <= next_amask;
      end
   end

   // interrupt feeds from the synchronised pins
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ext_int0_level_out <= 1'b1;
         ext_int1_level_out <= 1'b0;
         ext_int5_fall_out  <= 1'b0;
         p2_bit0_prev       <= 1'b0;
      end else begin
         ext_int0_level_out <= ext_int_ctrl[gpp_pkg::EXT_INT_EN_BIT] ? sp.p1[0]
                                                                   : 1'b1;
         ext_int1_level_out <= sp.p1[1];
         ext_int5_fall_out  <= p2_bit0_prev & ~sp.p2[0];
         p2_bit0_prev       <= sp.p2[0];
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   property p_p0_reset;
      @(posedge mclk_in) disable iff (1'b0)
      !resetn_in |=> (p0_latch == 8'hff) && (p0_drive == 8'h00) && (pins_oe_out.p0 == 8'h00);
   endproperty
   a_p0_reset: assert property (p_p0_reset) else $error("port0 reset values wrong");

   property p_p1_p3_reset;
      @(posedge mclk_in) disable iff (1'b0)
      !resetn_in |=> (p1_dir == 7'h00) && (p1_latch == 7'h00) && (p3_dir == 8'h00)
                     && conv_ctrl[gpp_pkg::CONV_ANALOG_OFF_BIT] && (p2_latch == 3'h7)
                     && (p3_latch == 8'h00);
   endproperty
   a_p1_p3_reset: assert property (p_p1_p3_reset) else $error("port1/3 reset wrong");

   property p_pin_read;
      (state == gpp_pkg::st_first_bus_state) && read_in && (idx == gpp_pkg::IDX_P0_PIN)
      |=> (readdata_out[7:0] == $past(sp.p0)) && !waitrequest_out;
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin read not from first state");

   property p_write_second;
      (state == gpp_pkg::st_second_bus_state) && write_in && byteenable_in[0]
      && (idx == gpp_pkg::IDX_P0_LATCH)
      |=> (pins_out.p0 == $past(writedata_in[7:0])) && (p0_latch == pins_out.p0);
   endproperty
   a_write_second: assert property (p_write_second) else $error("write not at second state");

   property p_p0_drive;
      ##1 (pins_oe_out.p0 == (~p0_latch | p0_drive)) && (pins_out.p0 == p0_latch);
   endproperty
   a_p0_drive: assert property (p_p0_drive) else $error("port0 drive mismatch");

   property p_analog;
      ##1 ((pins_oe_out.p3 & amask) == 8'h00) && (pins_oe_out.p3 == (p3_dir & ~amask));
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin driven");

   property p_stop_float;
      ##1 mode_ctrl[gpp_pkg::MODE_STOP_BIT] |-> !pins_oe_out.p2[0];
   endproperty
   a_stop_float: assert property (p_stop_float) else $error("stop pin not floating");

   property p_int0_sel;
      !ext_int_ctrl[gpp_pkg::EXT_INT_EN_BIT] ##1 !ext_int_ctrl[gpp_pkg::EXT_INT_EN_BIT]
      |-> ext_int0_level_out;
   endproperty
   a_int0_sel: assert property (p_int0_sel) else $error("int0 fed while port");

   property p_bus_answer;
      (state == gpp_pkg::st_idle) && (read_in || write_in) |=> waitrequest_out ##1 !waitrequest_out;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

   c_p0_write: cover property (wr_now && (idx == gpp_pkg::IDX_P0_LATCH));
   c_p3_analog: cover property (amask != 8'h00 && p3_dir != 8'h00);
   c_int5_fall: cover property (ext_int5_fall_out);
   c_p1_read: cover property ((state == gpp_pkg::st_first_bus_state) && read_in
                              && (idx == gpp_pkg::IDX_P1_LATCH));

endmodule // gpp_top

// >>> verification/gpp_pin_model.sv
`timescale 1ns/100ps
module gpp_pin_model (
   // device side
   input  wire gpp_pkg::gpp_pins_t pins_out_in,
   input  wire gpp_pkg::gpp_pins_t pins_oe_in,
   // far-side drivers
   input  wire gpp_pkg::gpp_pins_t ext_val_in,
   input  wire gpp_pkg::gpp_pins_t ext_en_in,
   // resolved pin levels
   output gpp_pkg::gpp_pins_t      level_out
);
   // driven pin follows device, released pin follows load or pull-up
   always_comb begin
      for (int i = 0; i < 26; i++) begin
         if (pins_oe_in[i]) begin
            level_out[i] = pins_out_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else begin
            level_out[i] = 1'b1;
         end
      end
   end
endmodule // gpp_pin_model

// >>> verification/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
   logic               mclk_in         = 1'b0;
   logic               resetn_in       = 1'b0;
   logic [7:0]         address_in      = 8'h00;
   logic               read_in         = 1'b0;
   logic               write_in        = 1'b0;
   logic [31:0]        writedata_in    = 32'h0;
   logic [3:0]         byteenable_in   = 4'h1;
   logic [31:0]        readdata_out;
   logic               waitrequest_out;
   gpp_pkg::gpp_pins_t pins_in;
   gpp_pkg::gpp_pins_t pins_out;
   gpp_pkg::gpp_pins_t pins_oe_out;
   logic               ext_int0_level_out;
   logic               ext_int1_level_out;
   logic               ext_int5_fall_out;
   logic [7:0]         analog_pins_out;
   gpp_pkg::gpp_pins_t ext_val         = '1;
   gpp_pkg::gpp_pins_t ext_en          = '1;
   logic [7:0]         exp_q[$];
   logic [7:0]         msk_q[$];
   logic [7:0]         exp_b, msk_b, r, e, d, l, m;
   int                 fails = 0, n_tests = 0, cycles = 0, fall_cnt = 0;

   always #5 mclk_in = ~mclk_in;

   gpp_top dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
      .byteenable_in(byteenable_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .pins_in(pins_in), .pins_out(pins_out),
      .pins_oe_out(pins_oe_out), .ext_int0_level_out(ext_int0_level_out),
      .ext_int1_level_out(ext_int1_level_out), .ext_int5_fall_out(ext_int5_fall_out),
      .analog_pins_out(analog_pins_out));

   gpp_pin_model model_u (.pins_out_in(pins_out), .pins_oe_in(pins_oe_out),
      .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pins_in));

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // read answers compared against the oldest note; hang guard
   always @(posedge mclk_in) begin
      cycles++;
      if (ext_int5_fall_out === 1'b1) fall_cnt++;
      if (read_in && waitrequest_out === 1'b0 && exp_q.size() > 0) begin
         exp_b = exp_q.pop_front();
         msk_b = msk_q.pop_front();
         `CHK(readdata_out & {24'hffffff, msk_b}, {24'h0, exp_b & msk_b})
      end
      if (cycles > 20000) begin
         fails++;
         results;
      end
   end

   task automatic bus_write(input logic [5:0] idx, input logic [7:0] dat,
                            input logic [3:0] be = 4'h1);
      @(posedge mclk_in);
      address_in    <= {idx, 2'b00};
      writedata_in  <= {24'h0, dat};
      byteenable_in <= be;
      write_in      <= 1'b1;
      do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
      write_in      <= 1'b0;
   endtask

   task automatic bus_read(input logic [5:0] idx, input logic [7:0] ex,
                           input logic [7:0] mk = 8'hff);
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      @(posedge mclk_in);
      address_in <= {idx, 2'b00};
      read_in    <= 1'b1;
      do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
      read_in    <= 1'b0;
   endtask

   // lets synchronisers and registered outputs follow
   task automatic settle;
      repeat (5) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask

   initial begin
      ext_val.p1 = 7'h00;
      ext_val.p3 = 8'h00;
      r = 8'($urandom(32'h2e9cee60));
      repeat (6) @(posedge mclk_in);
      resetn_in <= 1'b1;
      settle;
      `CHK(pins_oe_out, 26'h0)
      `CHK(pins_out.p0, 8'hff)
      `CHK(ext_int0_level_out, 1'b1)
      bus_read(gpp_pkg::IDX_P0_LATCH, 8'hff);
      bus_read(gpp_pkg::IDX_P0_DRIVE, 8'h00);
      bus_read(gpp_pkg::IDX_P1_DIR, 8'h00);
      bus_read(gpp_pkg::IDX_P1_LATCH, 8'h00);
      bus_read(gpp_pkg::IDX_P2_LATCH, 8'h07, 8'h07);
      bus_read(gpp_pkg::IDX_P3_DIR, 8'h00);
      bus_read(gpp_pkg::IDX_CONV, 8'h10);
      bus_read(6'h05, 8'h00);
      $display("test reset done");
      r = 8'($urandom);
      bus_write(gpp_pkg::IDX_P0_LATCH, r);
      settle;
      `CHK(pins_oe_out.p0, ~r)
      `CHK(pins_out.p0, r)
      bus_write(gpp_pkg::IDX_P0_DRIVE, 8'hff);
      settle;
      `CHK(pins_oe_out.p0, 8'hff)
      bus_read(gpp_pkg::IDX_P0_LATCH, r);
      bus_read(gpp_pkg::IDX_P0_PIN, r);
      e = 8'($urandom);
      @(posedge mclk_in);
      ext_val.p0 <= e;
      bus_write(gpp_pkg::IDX_P0_DRIVE, 8'h00);
      bus_write(gpp_pkg::IDX_P0_LATCH, 8'hff);
      settle;
      bus_read(gpp_pkg::IDX_P0_PIN, e);
      $display("test port0 done");
      d = 8'($urandom) & 8'h7f;
      l = 8'($urandom) & 8'h7f;
      e = 8'($urandom);
      @(posedge mclk_in);
      ext_val.p1 <= e[6:0];
      bus_write(gpp_pkg::IDX_P1_LATCH, l);
      bus_write(gpp_pkg::IDX_P1_DIR, d);
      settle;
      `CHK(pins_oe_out.p1, d[6:0])
      `CHK(pins_out.p1, l[6:0])
      bus_read(gpp_pkg::IDX_P1_LATCH, (l & d) | (e & ~d), 8'h7f);
      bus_write(gpp_pkg::IDX_P1_DIR, 8'h02);
      bus_write(gpp_pkg::IDX_P1_LATCH, 8'h00);
      @(posedge mclk_in);
      ext_val.p1 <= 7'h7e;
      settle;
      `CHK(ext_int1_level_out, 1'b0)
      `CHK(ext_int0_level_out, 1'b1)
      bus_write(gpp_pkg::IDX_P1_LATCH, 8'h02);
      bus_write(gpp_pkg::IDX_EXT_INT, 8'h40);
      settle;
      `CHK(ext_int1_level_out, 1'b1)
      `CHK(ext_int0_level_out, 1'b0)
      bus_read(gpp_pkg::IDX_EXT_INT, 8'h40, 8'h40);
      $display("test port1 done");
      bus_write(gpp_pkg::IDX_P2_LATCH, 8'h07);
      settle;
      fall_cnt = 0;
      bus_write(gpp_pkg::IDX_P2_LATCH, 8'h06);
      settle;
      `CHK(fall_cnt, 1)
      `CHK(pins_oe_out.p2, 3'b001)
      bus_read(gpp_pkg::IDX_P2_PIN, 8'h06, 8'h07);
      bus_read(gpp_pkg::IDX_P2_LATCH, 8'h06, 8'h07);
      bus_write(gpp_pkg::IDX_MODE, 8'h01);
      settle;
      `CHK(pins_oe_out.p2, 3'b000)
      bus_write(gpp_pkg::IDX_MODE, 8'h02);
      bus_write(gpp_pkg::IDX_P2_LATCH, 8'h00);
      settle;
      `CHK(pins_oe_out.p2, 3'b001)
      bus_write(gpp_pkg::IDX_MODE, 8'h00);
      settle;
      `CHK(pins_oe_out.p2, 3'b111)
      $display("test port2 done");
      d = 8'($urandom);
      l = 8'($urandom);
      e = 8'($urandom);
      @(posedge mclk_in);
      ext_val.p3 <= e;
      bus_write(gpp_pkg::IDX_P3_LATCH, l);
      bus_write(gpp_pkg::IDX_P3_DIR, d);
      bus_write(gpp_pkg::IDX_P3_DIR, 8'hff, 4'h0);
      settle;
      `CHK(pins_oe_out.p3, d)
      `CHK(pins_out.p3, l)
      bus_read(gpp_pkg::IDX_P3_DIR, d);
      bus_read(gpp_pkg::IDX_P3_LATCH, (l & d) | (e & ~d));
      // no latch writes while analog pins are selected
      for (int s = 0; s < 8; s++) begin
         m = (s < 6) ? (8'h04 << s) : 8'h00;
         bus_write(gpp_pkg::IDX_CONV, 8'(s));
         settle;
         `CHK(analog_pins_out, m)
         `CHK(pins_oe_out.p3, d & ~m)
         `CHK(pins_out.p3, l & ~m)
         bus_read(gpp_pkg::IDX_P3_LATCH, (l & (d | m)) | (e & ~d & ~m));
      end
      bus_write(gpp_pkg::IDX_CONV, 8'h10);
      settle;
      `CHK(analog_pins_out, 8'h00)
      bus_write(gpp_pkg::IDX_P3_DIR, 8'h00);
      settle;
      `CHK(pins_oe_out.p3, 8'h00)
      $display("test port3 done");
      results;
   end
endmodule // testbench
